// File: core/uic_pkg.sv
package uic_pkg;

  // ---------------------------------------------
  // Register addresses on A2..A0
  // ---------------------------------------------
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_IER = 3'h1;
  localparam logic [2:0] ADDR_ISR_FCR = 3'h2;
  localparam logic [2:0] ADDR_LSR = 3'h5;
  localparam logic [2:0] ADDR_MSR = 3'h6;

  // ---------------------------------------------
  // Enable register fields
  // ---------------------------------------------
  localparam int IER_RX = 0;
  localparam int IER_TX = 1;
  localparam int IER_LS = 2;
  localparam int IER_MS = 3;
  localparam int IER_SLEEP = 4;
  localparam int IER_XOFF = 5;
  localparam int IER_RTS = 6;
  localparam int IER_CTS = 7;
  localparam logic [7:0] IER_RST = 8'h00;

  // ---------------------------------------------
  // FIFO control fields
  // ---------------------------------------------
  localparam int FCR_EN = 0;
  localparam int FCR_RXRST = 1;
  localparam int FCR_TXRST = 2;
  localparam int FCR_DMA = 3;
  localparam int FCR_TXTRIG = 4;
  localparam int FCR_RXTRIG = 6;
  localparam logic [7:0] FCR_RST = 8'h00;

  // ---------------------------------------------
  // Status codes, bits 5..0
  // ---------------------------------------------
  localparam logic [5:0] CODE_LS = 6'h06;
  localparam logic [5:0] CODE_TO = 6'h0C;
  localparam logic [5:0] CODE_RX = 6'h04;
  localparam logic [5:0] CODE_TX = 6'h02;
  localparam logic [5:0] CODE_MS = 6'h00;
  localparam logic [5:0] CODE_XOFF = 6'h10;
  localparam logic [5:0] CODE_FLOW = 6'h20;
  localparam logic [5:0] CODE_NONE = 6'h01;

  // ---------------------------------------------
  // Receive timeout length
  // ---------------------------------------------
  localparam int TO_CHARS = 4;
  localparam int TO_EXTRA_BITS = 12;

  // Interrupt sources in priority order
  typedef enum {
    SRC_NONE, SRC_LS, SRC_TO, SRC_RX, SRC_TX, SRC_MS, SRC_XOFF, SRC_FLOW
  } uic_src_t;

endpackage : uic_pkg

// File: core/uic_edge_det.sv
`timescale 1ns/10ps
// Rising edge detector for a vector of levels
module uic_edge_det #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Levels and their rising edges
  input wire logic [WIDTH-1:0] level_in,
  output logic [WIDTH-1:0] rise_out
);

  // Previous sample of each level
  logic [WIDTH-1:0] prev_ff;

  // Track levels every cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      // Follow the level in reset so a high idle level gives no false edge
      prev_ff <= level_in;
    end else begin
      prev_ff <= level_in;
    end
  end

  // Pulse for one cycle on a low to high change
  assign rise_out = level_in & ~prev_ff;

endmodule : uic_edge_det

// File: core/uic_rx_timeout.sv
`timescale 1ns/10ps
// Receive timeout: bit times of silence with data waiting
module uic_rx_timeout #(
  parameter int CNT_W = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control
  input wire logic arm,
  input wire logic restart,
  input wire logic bit_tick,
  input wire logic [3:0] char_bits,
  // Timeout level, held until restart or disarm
  output logic expired
);

  // Bit time counter and expiry flag
  logic [CNT_W-1:0] count_ff;
  logic done_ff;
  logic [CNT_W-1:0] limit;

  // Four characters plus twelve bit times
  assign limit = CNT_W'(uic_pkg::TO_CHARS * int'(char_bits) + uic_pkg::TO_EXTRA_BITS);

  // Count bit ticks while armed and quiet
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      count_ff <= '0;
      done_ff <= 1'b0;
    end else if (!arm || restart) begin
      // New character, a read or an empty FIFO restarts
      count_ff <= '0;
      done_ff <= 1'b0;
    end else if (bit_tick && !done_ff) begin
      if (count_ff + CNT_W'(1) >= limit) begin
        done_ff <= 1'b1;
      end
      count_ff <= count_ff + CNT_W'(1);
    end
  end

  assign expired = done_ff;

endmodule : uic_rx_timeout

// File: core/uic_core.sv
`timescale 1ns/10ps
// Interrupt enable, status and FIFO enable logic of one channel
module uic_core (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Parallel register bus
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n,
  input wire logic [7:0] ext_rd_data,
  // Mode inputs from other channel registers
  input wire logic dlab_sel,
  input wire logic efr_access,
  input wire logic enh_func_en,
  input wire logic auto_rts_en,
  input wire logic auto_cts_en,
  input wire logic rs485_auto,
  input wire logic lsr_err_immediate,
  // Receiver status
  input wire logic rx_push,
  input wire logic rx_fifo_empty,
  input wire logic rx_at_trig,
  input wire logic rx_overrun,
  input wire logic rx_err_evt,
  input wire logic [2:0] head_err,
  input wire logic rx_fifo_err,
  input wire logic bit_tick,
  input wire logic [3:0] char_bits,
  input wire logic xoff_match,
  input wire logic xon_match,
  input wire logic special_match,
  // Transmitter status
  input wire logic thr_empty,
  input wire logic tx_below_trig,
  input wire logic tx_fifo_empty,
  input wire logic tx_all_empty,
  // Modem and flow pins
  input wire logic [3:0] msr_delta,
  input wire logic cts_in,
  input wire logic rts_out,
  // Interrupt output
  output logic irq,
  // Access pulses to neighbouring blocks
  output logic rhr_rd_pulse,
  output logic thr_wr_pulse,
  output logic msr_rd_pulse,
  output logic lsr_rd_pulse,
  // FIFO control outputs and sleep enable
  output logic fifo_en,
  output logic rx_fifo_rst,
  output logic tx_fifo_rst,
  output logic dma_mode,
  output logic [1:0] tx_trig_sel,
  output logic [1:0] rx_trig_sel,
  output logic sleep_en
);

  // ---------------------------------------------
  // Declarations
  // ---------------------------------------------
  // Bus activity levels and their starts
  logic rd_act;
  logic wr_act;
  logic rd_start;
  logic wr_start;
  // Decoded accesses
  logic ier_wr;
  logic fcr_wr;
  logic isr_rd;
  logic lsr_rd;
  logic rhr_rd;
  logic thr_wr;
  logic msr_rd;
  // Stored registers
  logic [7:0] ier_ff;
  logic [7:0] fcr_ff;
  logic [7:0] data_out_ff;
  // Line status pieces
  logic data_ready_ff;
  logic overrun_ff;
  logic [7:0] lsr_val;
  // Sticky pending flags and read delay
  logic ls_pend_ff;
  logic tx_pend_ff;
  logic xoff_pend_ff;
  logic spec_pend_ff;
  logic rts_pend_ff;
  logic cts_pend_ff;
  logic rhr_rd_d_ff;
  // Level conditions
  logic tx_cond;
  logic rx_cond;
  logic head_err_any;
  logic timeout;
  // Edge detector wiring
  logic [5:0] lvl_vec;
  logic [5:0] rise_vec;
  // Gated sources and encoder result
  logic p_ls, p_to, p_rx, p_tx, p_ms, p_xo, p_fl;
  uic_pkg::uic_src_t top_src;
  logic [5:0] isr_code;
  logic [7:0] isr_val;
  // Output registers
  logic irq_ff;
  logic rhr_rd_ff;
  logic thr_wr_ff;
  logic msr_rd_ff;
  logic lsr_rd_ff;
  logic rx_rst_ff;
  logic tx_rst_ff;

  // ---------------------------------------------
  // Bus decode
  // ---------------------------------------------
  // Strobes are levels; act once at the start
  assign rd_act = !cs_n && !rd_n;
  assign wr_act = !cs_n && !wr_n;

  // Edges of bus, flow pins and status levels
  assign lvl_vec = {head_err_any, tx_cond, rts_out, cts_in, wr_act, rd_act};

  uic_edge_det #(
    .WIDTH(6)
  ) u_edges (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .level_in(lvl_vec),
    .rise_out(rise_vec)
  );

  assign rd_start = rise_vec[0];
  assign wr_start = rise_vec[1];

  // Register select by address and bank
  assign ier_wr = wr_start && addr == uic_pkg::ADDR_IER && !dlab_sel;
  assign fcr_wr = wr_start && addr == uic_pkg::ADDR_ISR_FCR && !efr_access;
  assign thr_wr = wr_start && addr == uic_pkg::ADDR_DATA && !dlab_sel;
  assign isr_rd = rd_start && addr == uic_pkg::ADDR_ISR_FCR && !efr_access;
  assign rhr_rd = rd_start && addr == uic_pkg::ADDR_DATA && !dlab_sel;
  assign lsr_rd = rd_start && addr == uic_pkg::ADDR_LSR;
  assign msr_rd = rd_start && addr == uic_pkg::ADDR_MSR;

  // ---------------------------------------------
  // Interrupt enable register
  // ---------------------------------------------
  // Low four bits always; upper four only in enhanced mode
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ier_ff <= uic_pkg::IER_RST;
    end else if (ier_wr) begin
      ier_ff[3:0] <= data_in[3:0];
      if (enh_func_en) begin
        ier_ff[7:4] <= data_in[7:4];
      end
    end
  end

  assign sleep_en = ier_ff[uic_pkg::IER_SLEEP];

  // ---------------------------------------------
  // FIFO control register
  // ---------------------------------------------
  // Write with bit 0 clear only disables the FIFOs
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fcr_ff <= uic_pkg::FCR_RST;
    end else if (fcr_wr) begin
      fcr_ff[uic_pkg::FCR_EN] <= data_in[uic_pkg::FCR_EN];
      if (data_in[uic_pkg::FCR_EN]) begin
        // Other bits only take effect with enable set
        fcr_ff[uic_pkg::FCR_DMA] <= data_in[uic_pkg::FCR_DMA];
        fcr_ff[7:6] <= data_in[7:6];
        if (enh_func_en) begin
          fcr_ff[5:4] <= data_in[5:4];
        end
      end
    end
  end

  // FIFO reset bits are self clearing pulses
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rx_rst_ff <= 1'b0;
      tx_rst_ff <= 1'b0;
    end else begin
      rx_rst_ff <= fcr_wr && data_in[uic_pkg::FCR_EN] && data_in[uic_pkg::FCR_RXRST];
      tx_rst_ff <= fcr_wr && data_in[uic_pkg::FCR_EN] && data_in[uic_pkg::FCR_TXRST];
    end
  end

  assign fifo_en = fcr_ff[uic_pkg::FCR_EN];
  assign dma_mode = fcr_ff[uic_pkg::FCR_DMA];
  assign tx_trig_sel = fcr_ff[uic_pkg::FCR_TXTRIG +: 2];
  assign rx_trig_sel = fcr_ff[uic_pkg::FCR_RXTRIG +: 2];
  assign rx_fifo_rst = rx_rst_ff;
  assign tx_fifo_rst = tx_rst_ff;

  // ---------------------------------------------
  // Line status register
  // ---------------------------------------------
  // Data ready: a push wins over the empty clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      data_ready_ff <= 1'b0;
    end else if (rx_push) begin
      data_ready_ff <= 1'b1;
    end else if (rx_fifo_empty) begin
      data_ready_ff <= 1'b0;
    end
  end

  // Overrun is sticky until the line status is read
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      overrun_ff <= 1'b0;
    end else if (rx_overrun) begin
      overrun_ff <= 1'b1;
    end else if (lsr_rd) begin
      overrun_ff <= 1'b0;
    end
  end

  // Error of current byte, empties, error anywhere
  assign head_err_any = |head_err;
  assign lsr_val = {rx_fifo_err && fifo_en, tx_all_empty, thr_empty,
                    head_err, overrun_ff, data_ready_ff};

  // ---------------------------------------------
  // Source conditions
  // ---------------------------------------------
  // Receive ready: trigger level or holding character
  assign rx_cond = fifo_en ? rx_at_trig : data_ready_ff;

  // Transmit ready condition by mode
  always_comb begin
    if (rs485_auto) begin
      tx_cond = tx_all_empty;
    end else if (fifo_en) begin
      tx_cond = tx_below_trig || tx_fifo_empty;
    end else begin
      tx_cond = thr_empty;
    end
  end

  // Receive timeout timer, FIFO mode only
  uic_rx_timeout #(
    .CNT_W(8)
  ) u_timeout (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .arm(fifo_en && !rx_fifo_empty),
    .restart(rx_push || rhr_rd),
    .bit_tick(bit_tick),
    .char_bits(char_bits),
    .expired(timeout)
  );

  // Delay register so errors are checked on the new head
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rhr_rd_d_ff <= 1'b0;
    end else begin
      rhr_rd_d_ff <= rhr_rd;
    end
  end

  // ---------------------------------------------
  // Sticky pending flags
  // ---------------------------------------------
  // Line status: overrun at once, errors by mode
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ls_pend_ff <= 1'b0;
    end else if (rx_overrun) begin
      ls_pend_ff <= 1'b1;
    end else if (lsr_err_immediate && rx_err_evt) begin
      ls_pend_ff <= 1'b1;
    end else if (!lsr_err_immediate && head_err_any && (rise_vec[5] || rhr_rd_d_ff)) begin
      ls_pend_ff <= 1'b1;
    end else if (lsr_rd) begin
      ls_pend_ff <= 1'b0;
    end
  end

  // Transmit ready: new condition or enable while true
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_pend_ff <= 1'b0;
    end else if (rise_vec[4]) begin
      tx_pend_ff <= 1'b1;
    end else if (ier_wr && data_in[uic_pkg::IER_TX] && !ier_ff[uic_pkg::IER_TX] && tx_cond) begin
      tx_pend_ff <= 1'b1;
    end else if (thr_wr || (isr_rd && top_src == uic_pkg::SRC_TX)) begin
      tx_pend_ff <= 1'b0;
    end
  end

  // Xoff match: held until Xon or a status read
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      xoff_pend_ff <= 1'b0;
    end else if (xoff_match) begin
      xoff_pend_ff <= 1'b1;
    end else if (xon_match || (isr_rd && top_src == uic_pkg::SRC_XOFF)) begin
      xoff_pend_ff <= 1'b0;
    end
  end

  // Special character: cleared by read or next character
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      spec_pend_ff <= 1'b0;
    end else if (special_match) begin
      spec_pend_ff <= 1'b1;
    end else if (rx_push || (isr_rd && top_src == uic_pkg::SRC_XOFF)) begin
      spec_pend_ff <= 1'b0;
    end
  end

  // Flow pin rising edges under automatic flow control
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rts_pend_ff <= 1'b0;
      cts_pend_ff <= 1'b0;
    end else begin
      if (auto_rts_en && rise_vec[3]) begin
        rts_pend_ff <= 1'b1;
      end else if (msr_rd) begin
        rts_pend_ff <= 1'b0;
      end
      if (auto_cts_en && rise_vec[2]) begin
        cts_pend_ff <= 1'b1;
      end else if (msr_rd) begin
        cts_pend_ff <= 1'b0;
      end
    end
  end

  // ---------------------------------------------
  // Enable gating
  // ---------------------------------------------
  assign p_ls = ier_ff[uic_pkg::IER_LS] && ls_pend_ff;
  assign p_to = ier_ff[uic_pkg::IER_RX] && timeout;
  assign p_rx = ier_ff[uic_pkg::IER_RX] && rx_cond;
  assign p_tx = ier_ff[uic_pkg::IER_TX] && tx_pend_ff;
  assign p_ms = ier_ff[uic_pkg::IER_MS] && (|msr_delta);
  assign p_xo = enh_func_en && ier_ff[uic_pkg::IER_XOFF]
                && (xoff_pend_ff || spec_pend_ff);
  assign p_fl = enh_func_en
                && ((ier_ff[uic_pkg::IER_RTS] && rts_pend_ff)
                    || (ier_ff[uic_pkg::IER_CTS] && cts_pend_ff));

  // ---------------------------------------------
  // Priority encoder
  // ---------------------------------------------
  // Highest pending source; lower ones wait their turn
  always_comb begin
    if (p_ls) begin
      top_src = uic_pkg::SRC_LS;
    end else if (p_to) begin
      top_src = uic_pkg::SRC_TO;
    end else if (p_rx) begin
      top_src = uic_pkg::SRC_RX;
    end else if (p_tx) begin
      top_src = uic_pkg::SRC_TX;
    end else if (p_ms) begin
      top_src = uic_pkg::SRC_MS;
    end else if (p_xo) begin
      top_src = uic_pkg::SRC_XOFF;
    end else if (p_fl) begin
      top_src = uic_pkg::SRC_FLOW;
    end else begin
      top_src = uic_pkg::SRC_NONE;
    end
  end

  // Code for the winning source
  always_comb begin
    unique case (top_src)
      uic_pkg::SRC_LS: isr_code = uic_pkg::CODE_LS;
      uic_pkg::SRC_TO: isr_code = uic_pkg::CODE_TO;
      uic_pkg::SRC_RX: isr_code = uic_pkg::CODE_RX;
      uic_pkg::SRC_TX: isr_code = uic_pkg::CODE_TX;
      uic_pkg::SRC_MS: isr_code = uic_pkg::CODE_MS;
      uic_pkg::SRC_XOFF: isr_code = uic_pkg::CODE_XOFF;
      uic_pkg::SRC_FLOW: isr_code = uic_pkg::CODE_FLOW;
      uic_pkg::SRC_NONE: isr_code = uic_pkg::CODE_NONE;
    endcase
  end

  // FIFO enable mirrored in the top two bits
  assign isr_val = {fifo_en, fifo_en, isr_code};

  // ---------------------------------------------
  // Read data
  // ---------------------------------------------
  // Captured at the start of a read, held until the next
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      data_out_ff <= 8'h00;
    end else if (rd_start) begin
      if (addr == uic_pkg::ADDR_IER && !dlab_sel) begin
        data_out_ff <= ier_ff;
      end else if (addr == uic_pkg::ADDR_ISR_FCR && !efr_access) begin
        data_out_ff <= isr_val;
      end else if (addr == uic_pkg::ADDR_LSR) begin
        data_out_ff <= lsr_val;
      end else begin
        data_out_ff <= ext_rd_data;
      end
    end
  end

  assign data_out = data_out_ff;
  // Drive the bus only during the read strobe
  assign data_oe_n = !(rd_act && rst_n);

  // ---------------------------------------------
  // Interrupt output and access pulses
  // ---------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq_ff <= 1'b0;
      rhr_rd_ff <= 1'b0;
      thr_wr_ff <= 1'b0;
      msr_rd_ff <= 1'b0;
      lsr_rd_ff <= 1'b0;
    end else begin
      irq_ff <= top_src != uic_pkg::SRC_NONE;
      rhr_rd_ff <= rhr_rd;
      thr_wr_ff <= thr_wr;
      msr_rd_ff <= msr_rd;
      lsr_rd_ff <= lsr_rd;
    end
  end

  assign irq = irq_ff;
  assign rhr_rd_pulse = rhr_rd_ff;
  assign thr_wr_pulse = thr_wr_ff;
  assign msr_rd_pulse = msr_rd_ff;
  assign lsr_rd_pulse = lsr_rd_ff;

endmodule : uic_core

// File: test/uic_chk.sv
`timescale 1ns/10ps
// Checks at the pins of the interrupt control block
module uic_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register bus
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n,
  // Modes
  input wire logic dlab_sel,
  input wire logic efr_access,
  input wire logic enh_func_en,
  // Outputs under watch
  input wire logic irq,
  input wire logic rhr_rd_pulse,
  input wire logic thr_wr_pulse,
  input wire logic msr_rd_pulse,
  input wire logic lsr_rd_pulse,
  input wire logic fifo_en,
  input wire logic rx_fifo_rst,
  input wire logic tx_fifo_rst,
  input wire logic sleep_en
);
  // Strobe levels one cycle ago, to find access starts
  logic rd_q_ff;
  logic wr_q_ff;
  always_ff @(posedge clk_sys) begin
    rd_q_ff <= !cs_n && !rd_n;
    wr_q_ff <= !cs_n && !wr_n;
  end
  // First cycle of a read or a write
  wire rd_go = !cs_n && !rd_n && !rd_q_ff;
  wire wr_go = !cs_n && !wr_n && !wr_q_ff;
  wire isr_go = rd_go && addr == uic_pkg::ADDR_ISR_FCR && !efr_access;
  wire fcr_go = wr_go && addr == uic_pkg::ADDR_ISR_FCR && !efr_access;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ---------------------------------------------
  // Assertions
  // ---------------------------------------------
  a_isr_fifo_bits: assert property (isr_go |=> data_out[7:6] == {2{fifo_en}})
    else $error("status bits 7..6 differ from fifo enable");
  a_isr_code_set: assert property (isr_go |=> data_out[5:0] inside {6'h06, 6'h0C,
    6'h04, 6'h02, 6'h00, 6'h10, 6'h20, 6'h01}) else $error("illegal status code");
  a_lsr_rd_pulse: assert property (rd_go && addr == uic_pkg::ADDR_LSR
    |=> lsr_rd_pulse ##1 !lsr_rd_pulse) else $error("line status read pulse wrong");
  a_rhr_rd_pulse: assert property (rd_go && addr == uic_pkg::ADDR_DATA && !dlab_sel
    |=> rhr_rd_pulse) else $error("holding read pulse missing");
  a_msr_rd_pulse: assert property (rd_go && addr == uic_pkg::ADDR_MSR
    |=> msr_rd_pulse) else $error("modem read pulse missing");
  a_thr_wr_pulse: assert property (wr_go && addr == uic_pkg::ADDR_DATA && !dlab_sel
    |=> thr_wr_pulse) else $error("holding write pulse missing");
  a_fifo_rst_gate: assert property (rx_fifo_rst |-> fifo_en)
    else $error("fifo reset without fifo enable");
  a_fifo_en_source: assert property ($changed(fifo_en) |-> $past(fcr_go))
    else $error("fifo enable moved without write");
  a_fifo_en_value: assert property (fcr_go |=> fifo_en == $past(data_in[0]))
    else $error("fifo enable not taken from bit 0");
  a_sleep_locked: assert property (wr_go && addr == uic_pkg::ADDR_IER && !dlab_sel
    && !enh_func_en |=> $stable(sleep_en)) else $error("sleep bit written while locked");
  a_tx_rst_pulse: assert property (fcr_go && data_in[0] && data_in[2]
    |=> tx_fifo_rst ##1 !tx_fifo_rst) else $error("transmit fifo reset pulse wrong");
  a_oe_read_only: assert property (data_oe_n == (cs_n || rd_n))
    else $error("data output enable outside read strobe");
  // Main scenarios reached
  c_isr_read: cover property (isr_go);
  c_irq_up: cover property ($rose(irq));
  c_sleep_on: cover property ($rose(sleep_en));
  c_fifo_rst: cover property (rx_fifo_rst);
endmodule : uic_chk

// File: test/uic_host.sv
`timescale 1ns/10ps
// Host processor on the byte-wide register bus
module uic_host (
  // Clock
  input wire logic clk_sys,
  // Strobes and select
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [2:0] addr,
  // Data lines
  output logic [7:0] data_in,
  input wire logic [7:0] data_out
);
  // Idle bus at time zero
  initial begin
    {cs_n, rd_n, wr_n} = 3'h7;
    addr = 3'h0;
    data_in = 8'hA5;
  end
  // Write: held across the take edge and one more, then released
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    addr = a;
    data_in = d;
    {cs_n, wr_n} = 2'h0;
    repeat (2) @(posedge clk_sys);
    #1;
    {cs_n, wr_n} = 2'h3;
    // Released lines show no stale byte
    data_in = ~d;
  endtask : wr
  // Read: data taken the edge after the take edge
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1;
    addr = a;
    {cs_n, rd_n} = 2'h0;
    repeat (2) @(posedge clk_sys);
    #1;
    d = data_out;
    {cs_n, rd_n} = 2'h3;
  endtask : rd
endmodule : uic_host

// File: test/tb_uart_interrupt_control.sv
`timescale 1ns/10ps
// Bench for the interrupt control block of one serial channel
module tb_uart_interrupt_control;
  // Design pins
  logic clk_sys, rst_n, cs_n, rd_n, wr_n, data_oe_n, irq, txe;
  logic [2:0] addr, head_err, pv;
  logic [7:0] data_in, data_out, ext_rd_data, rd_v;
  logic dlab_sel, efr_access, enh_func_en, auto_rts_en, auto_cts_en, rs485_auto;
  logic lsr_err_immediate, rx_push, rx_fifo_empty, rx_at_trig, rx_overrun, rx_err_evt;
  logic rx_fifo_err, bit_tick, xoff_match, xon_match, special_match, cts_in, rts_out;
  logic thr_empty, tx_below_trig, tx_fifo_empty, tx_all_empty, fifo_en, rx_fifo_rst;
  logic [3:0] char_bits, msr_delta;
  logic rhr_rd_pulse, thr_wr_pulse, msr_rd_pulse, lsr_rd_pulse;
  logic tx_fifo_rst, dma_mode, sleep_en;
  logic [1:0] tx_trig_sel, rx_trig_sel;
  int failures, checked;
  // Transmit levels move together, event pulses from one vector
  assign {thr_empty, tx_below_trig, tx_fifo_empty, tx_all_empty} = {4{txe}};
  assign {rx_push, rx_overrun, xoff_match} = pv;
  uic_core uut (.*);
  uic_host host (.*);
  always #10 clk_sys = ~clk_sys;
  // Compare one byte
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic tk(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tk
  task automatic pls(input logic [2:0] p);
    pv = p;
    tk(1);
    pv = 3'h0;
  endtask : pls
  task automatic interrupt_status(input logic [7:0] e);
    host.rd(uic_pkg::ADDR_ISR_FCR, rd_v);
    chk("isr", e, rd_v);
  endtask : interrupt_status
  task automatic line_status_reg(input logic [7:0] e);
    host.rd(uic_pkg::ADDR_LSR, rd_v);
    chk("lsr", e, rd_v);
  endtask : line_status_reg
  task automatic irqc(input logic e);
    chk("irq", {7'h0, e}, {7'h0, irq});
  endtask : irqc
  // Bounded wait for the interrupt level
  task automatic wirq(input logic e);
    for (int i = 0; i < 80 && irq !== e; i++) @(posedge clk_sys);
    #1;
    irqc(e);
    if (irq !== e) tally_and_finish();
  endtask : wirq
  task automatic done(input string n);
    $display("test %s finished", n);
  endtask : done
  task automatic tally_and_finish();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    {rst_n, dlab_sel, efr_access, enh_func_en, auto_rts_en, auto_cts_en, rs485_auto} = '0;
    {lsr_err_immediate, rx_at_trig, rx_err_evt, rx_fifo_err, bit_tick, head_err} = '0;
    {xon_match, special_match, cts_in, rts_out, msr_delta, ext_rd_data, pv} = '0;
    {rx_fifo_empty, txe, clk_sys} = 3'h6;
    char_bits = 4'hA;
    {failures, checked} = '0;
    tk(16);
    rst_n = 1'b1;
    tk(2);
    interrupt_status(8'h01);
    irqc(1'b0);
    host.wr(uic_pkg::ADDR_ISR_FCR, 8'h03);
    chk("fifo_en", 8'h01, {7'h0, fifo_en});
    host.wr(uic_pkg::ADDR_ISR_FCR, 8'h02);
    chk("fifo_en", 8'h00, {7'h0, fifo_en});
    host.wr(uic_pkg::ADDR_ISR_FCR, 8'h03);
    interrupt_status(8'hC1);
    done("reset_fifo");
    // Transmit ready: enable while empty, then refill and write
    host.wr(uic_pkg::ADDR_IER, 8'h02);
    wirq(1'b1);
    interrupt_status(8'hC2);
    wirq(1'b0);
    txe = 1'b0;
    tk(2);
    txe = 1'b1;
    wirq(1'b1);
    host.wr(uic_pkg::ADDR_DATA, 8'h55);
    wirq(1'b0);
    done("tx");
    // Several sources at once, serviced by priority
    host.wr(uic_pkg::ADDR_IER, 8'h0D);
    {rx_fifo_empty, rx_at_trig, msr_delta} = 6'h11;
    pls(3'h6);
    tk(3);
    interrupt_status(8'hC6);
    line_status_reg(8'h63);
    interrupt_status(8'hC4);
    rx_at_trig = 1'b0;
    interrupt_status(8'hC0);
    host.rd(uic_pkg::ADDR_MSR, rd_v);
    msr_delta = 4'h0;
    interrupt_status(8'hC1);
    rx_fifo_empty = 1'b1;
    line_status_reg(8'h60);
    // Error on the head byte, reported when it reaches the head
    head_err = 3'h2;
    wirq(1'b1);
    line_status_reg(8'h68);
    head_err = 3'h0;
    wirq(1'b0);
    done("priority");
    // Receive timeout: 4 * 10 + 12 ticks of silence
    host.wr(uic_pkg::ADDR_IER, 8'h01);
    rx_fifo_empty = 1'b0;
    pls(3'h4);
    bit_tick = 1'b1;
    tk(45);
    irqc(1'b0);
    tk(15);
    irqc(1'b1);
    interrupt_status(8'hCC);
    host.rd(uic_pkg::ADDR_DATA, rd_v);
    wirq(1'b0);
    {bit_tick, rx_fifo_empty} = 2'h1;
    done("timeout");
    // Upper enables locked, then Xoff and flow pin sources
    host.wr(uic_pkg::ADDR_IER, 8'hF0);
    chk("sleep_en", 8'h00, {7'h0, sleep_en});
    enh_func_en = 1'b1;
    host.wr(uic_pkg::ADDR_IER, 8'h30);
    chk("sleep_en", 8'h01, {7'h0, sleep_en});
    host.wr(uic_pkg::ADDR_ISR_FCR, 8'hFF);
    chk("fcr_out", 8'hF9, {rx_trig_sel, tx_trig_sel, dma_mode, 2'h0, fifo_en});
    host.wr(uic_pkg::ADDR_IER, 8'hA0);
    pls(3'h1);
    wirq(1'b1);
    interrupt_status(8'hD0);
    wirq(1'b0);
    // Xoff again, this time cleared by Xon
    pls(3'h1);
    wirq(1'b1);
    xon_match = 1'b1;
    tk(1);
    xon_match = 1'b0;
    wirq(1'b0);
    // Special character, cleared by the next character
    special_match = 1'b1;
    tk(1);
    special_match = 1'b0;
    wirq(1'b1);
    pls(3'h4);
    wirq(1'b0);
    {auto_cts_en, cts_in} = 2'h3;
    wirq(1'b1);
    interrupt_status(8'hE0);
    host.rd(uic_pkg::ADDR_MSR, rd_v);
    wirq(1'b0);
    done("enhanced");
    // Polled mode: errors visible, no interrupt
    host.wr(uic_pkg::ADDR_IER, 8'h00);
    pls(3'h2);
    tk(6);
    irqc(1'b0);
    line_status_reg(8'h62);
    host.wr(uic_pkg::ADDR_ISR_FCR, 8'h00);
    interrupt_status(8'h01);
    chk("fcr_out", 8'hF8, {rx_trig_sel, tx_trig_sel, dma_mode, 2'h0, fifo_en});
    done("polled");
    tally_and_finish();
  end
endmodule : tb_uart_interrupt_control
bind uic_core uic_chk chk_i (.*);
